// ===== bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ==========================================================
  // Signals
  logic core_clk, arst_n, iso_sample_stb, direct_mode, cal_stb;
  logic [2:0][11:0] leg_sample, cal_lo_meas, cal_hi_meas;
  logic [2:0][11:0] cal_offset, cal_span;
  logic [2:0] mp_fault_cmd, leg_cmd, ai_leg_report, cal_leg_bad, out_disc;
  logic fault_clear, load_sense, triac_mode, load_drive, fault_led;
  logic chassis_alarm, ai_input_fault, sw_fail, stuck_on, stuck_off;
  logic [1:0] fault_mode;
  int n_errors;
  int num_checks;
  localparam int SMP = 50;

  tmrd_diag #(.SAMPLE_CYC(SMP), .INV3_CYC(20), .WATCH_CYC(40),
    .GLITCH_CYC(100), .DIAG_GAP_CYC(30), .STEP2_CYC(10)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .leg_sample(leg_sample),
    .iso_sample_stb(iso_sample_stb), .direct_mode(direct_mode),
    .cal_stb(cal_stb), .cal_lo_meas(cal_lo_meas),
    .cal_hi_meas(cal_hi_meas), .mp_fault_cmd(mp_fault_cmd),
    .fault_clear(fault_clear), .leg_cmd(leg_cmd),
    .load_sense(load_sense), .triac_mode(triac_mode),
    .load_drive(load_drive), .fault_led(fault_led),
    .chassis_alarm(chassis_alarm), .ai_leg_report(ai_leg_report),
    .ai_input_fault(ai_input_fault), .cal_leg_bad(cal_leg_bad),
    .cal_offset(cal_offset), .cal_span(cal_span), .out_disc(out_disc),
    .sw_fail(sw_fail), .stuck_on(stuck_on), .stuck_off(stuck_off));

  tmrd_load_model i_load (.load_drive(load_drive),
    .fault_mode(fault_mode), .load_sense(load_sense));

  // ==========================================================
  // Helpers
  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

  task automatic check1(input logic exp, input logic got);
    num_checks++;
    if (got !== exp) n_errors++;
    if (got !== exp) $display("wrong value at %0t: got %h expected %h",
      $time, got, exp);
  endtask

  task automatic check3(input logic [2:0] exp, input logic [2:0] got);
    num_checks++;
    if (got !== exp) n_errors++;
    if (got !== exp) $display("wrong value at %0t: got %h expected %h",
      $time, got, exp);
  endtask

  task automatic checkw(input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) n_errors++;
    if (got !== exp) $display("wrong value at %0t: got %h expected %h",
      $time, got, exp);
  endtask

  // Late clear so a step one verdict raced by a new command is wiped too
  task automatic clr();
    repeat (4) @(posedge core_clk);
    fault_clear <= 1'h1;
    @(posedge core_clk);
    fault_clear <= 1'h0;
    repeat (3) @(negedge core_clk);
  endtask

  // Leg C gets value c, legs A and B read 1000
  task automatic iso_sample(input logic [11:0] c, output logic [2:0] rep);
    @(posedge core_clk);
    leg_sample <= {c, 12'h3e8, 12'h3e8};
    iso_sample_stb <= 1'h1;
    rep = 3'h0;
    @(posedge core_clk);
    iso_sample_stb <= 1'h0;
    repeat (4) begin
      @(negedge core_clk);
      rep = rep | ai_leg_report;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_vote();
    for (int v = 0; v < 8; v++) begin
      @(posedge core_clk);
      leg_cmd <= v[2:0];
      repeat (4) @(negedge core_clk);
      check1(maj3(v[2:0]), load_drive);
      check3(v[2:0] ^ {3{maj3(v[2:0])}}, out_disc);
    end
  endtask

  task automatic t_iso();
    logic [2:0] r;
    @(posedge core_clk);
    fault_mode <= 2'h0;
    leg_cmd <= 3'h7;
    direct_mode <= 1'h0;
    clr();
    iso_sample(12'h3fc, r);
    check3(3'h0, r);
    repeat (255) iso_sample(12'h3fd, r);
    check3(3'h4, r);
    check1(1'h0, ai_input_fault);
    iso_sample(12'h3e8, r);
    repeat (255) iso_sample(12'h3fd, r);
    check1(1'h0, ai_input_fault);
    iso_sample(12'h3fd, r);
    check1(1'h1, ai_input_fault);
    check1(1'h1, fault_led);
    check1(1'h1, chassis_alarm);
  endtask

  task automatic t_direct();
    int n;
    @(posedge core_clk);
    direct_mode <= 1'h1;
    leg_sample <= {12'h3f2, 12'h3e8, 12'h3e8};
    clr();
    repeat (1400) @(negedge core_clk);
    check1(1'h0, ai_input_fault);
    @(posedge core_clk);
    leg_sample <= {12'h3f3, 12'h3e8, 12'h3e8};
    n = 0;
    while (ai_input_fault !== 1'h1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    check1(1'h1, logic'(n >= 24 * SMP && n <= 25 * SMP + 4));
  endtask

  task automatic t_cal();
    logic [2:0] r;
    clr();
    @(posedge core_clk);
    cal_lo_meas <= {12'h140, 12'h0fc, 12'h104};
    cal_hi_meas <= {12'hf00, 12'hf00, 12'hf02};
    cal_stb <= 1'h1;
    @(posedge core_clk);
    cal_stb <= 1'h0;
    r = 3'h0;
    repeat (3) begin
      @(negedge core_clk);
      r = r | cal_leg_bad;
    end
    check3(3'h4, r);
    checkw(12'h004, cal_offset[0]);
    checkw(12'hdfe, cal_span[0]);
    checkw(12'hffc, cal_offset[1]);
    checkw(12'he04, cal_span[1]);
    checkw(12'h000, cal_offset[2]);
    check1(1'h1, fault_led);
    @(posedge core_clk);
    direct_mode <= 1'h0;
    cal_lo_meas <= {3{12'h100}};
    cal_stb <= 1'h1;
    @(posedge core_clk);
    cal_stb <= 1'h0;
    repeat (3) @(negedge core_clk);
    checkw(12'h004, cal_offset[0]);
  endtask

  // Long runs of stable commands; stuck switches come from the load model
  task automatic t_out(input logic [2:0] cmd, input logic [1:0] mode,
    input logic triac, input logic on, input logic off, input logic led,
    input logic glitch);
    logic seen;
    int run;
    int longest;
    @(posedge core_clk);
    leg_cmd <= cmd;
    fault_mode <= mode;
    triac_mode <= triac;
    clr();
    seen = 1'h0;
    run = 0;
    longest = 0;
    repeat (300) begin
      @(negedge core_clk);
      if (load_drive !== maj3(cmd)) run++;
      else run = 0;
      if (run > 0) seen = 1'h1;
      if (run > longest) longest = run;
    end
    check1(on, stuck_on);
    check1(off, stuck_off);
    check1(led, fault_led);
    check1(1'h0, sw_fail);
    check1(glitch, seen);
    check1(1'h1, logic'(longest < 100));
  endtask

  task automatic t_mp();
    clr();
    @(posedge core_clk);
    mp_fault_cmd <= 3'h2; // Processor verdict on leg B
    @(posedge core_clk);
    mp_fault_cmd <= 3'h0;
    repeat (3) @(negedge core_clk);
    check1(1'h1, fault_led);
    check1(1'h1, chassis_alarm);
    clr();
    check1(1'h0, fault_led);
  endtask

  // ==========================================================
  // Verdict
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // Generous limit, the full run needs under a fifth of it
  initial begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    close_out();
  end

  initial begin
    n_errors = 0;
    num_checks = 0;
    arst_n = 1'h0;
    leg_sample = '0;
    iso_sample_stb = 1'h0;
    direct_mode = 1'h0;
    cal_stb = 1'h0;
    cal_lo_meas = '0;
    cal_hi_meas = '0;
    mp_fault_cmd = 3'h0;
    fault_clear = 1'h0;
    leg_cmd = 3'h0;
    triac_mode = 1'h0;
    // Opposing load keeps every self check in step one during the vote
    fault_mode = 2'h3;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'h1;
    repeat (2) @(negedge core_clk);
    t_vote();
    t_iso();
    t_direct();
    t_cal();
    t_out(3'h7, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    t_out(3'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
    t_out(3'h7, 2'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
    t_out(3'h0, 2'h2, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
    t_out(3'h7, 2'h2, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
    t_out(3'h7, 2'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    t_mp();
    close_out();
  end
endmodule
`default_nettype wire

// ===== bench/tmrd_load_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Field load terminal seen through its loopback
module tmrd_load_model (
  input wire logic load_drive,
  input wire logic [1:0] fault_mode,
  output logic load_sense
);
  // Stuck modes ignore the drive, so no glitch ever reaches the sense line
  // Mode 3 opposes the drive to hold the self check in step one
  always_comb begin
    case (fault_mode)
      2'h1: load_sense = 1'h1;
      2'h2: load_sense = 1'h0;
      2'h3: load_sense = ~load_drive;
      default: load_sense = load_drive;
    endcase
  end
endmodule
`default_nettype wire

// ===== design/dummy_unused_never.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== design/tmrd_diag.sv
`timescale 1ns/10ps
`default_nettype none
module tmrd_diag #(
  parameter int W = 12,
  parameter int unsigned SAMPLE_CYC = tmrd_pkg::SAMPLE_CYC,
  parameter int unsigned INV3_CYC = tmrd_pkg::INV3_CYC,
  parameter int unsigned WATCH_CYC = tmrd_pkg::WATCH_CYC,
  parameter int unsigned GLITCH_CYC = tmrd_pkg::GLITCH_CYC,
  parameter int unsigned DIAG_GAP_CYC = tmrd_pkg::DIAG_GAP_CYC,
  parameter int unsigned STEP2_CYC = tmrd_pkg::STEP2_CYC,
  parameter logic [W-1:0] REF_LO = W'(256),
  parameter logic [W-1:0] REF_HI = W'(3840),
  parameter logic [W-1:0] CAL_TOL = W'(16)
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [2:0][W-1:0] leg_sample,
  input wire logic iso_sample_stb,
  input wire logic direct_mode,
  input wire logic cal_stb,
  input wire logic [2:0][W-1:0] cal_lo_meas,
  input wire logic [2:0][W-1:0] cal_hi_meas,
  input wire logic [2:0] mp_fault_cmd,
  input wire logic fault_clear,
  input wire logic [2:0] leg_cmd,
  input wire logic load_sense,
  input wire logic triac_mode,
  output logic load_drive,
  output logic fault_led,
  output logic chassis_alarm,
  output logic [2:0] ai_leg_report,
  output logic ai_input_fault,
  output logic [2:0] cal_leg_bad,
  output logic [2:0][W-1:0] cal_offset,
  output logic [2:0][W-1:0] cal_span,
  output logic [2:0] out_disc,
  output logic sw_fail,
  output logic stuck_on,
  output logic stuck_off
);
  // ==========================================================
  // State
  typedef struct packed {
    tmrd_pkg::tmrd_ov_state_type ov;
    logic [31:0] tmr;
    logic [31:0] smp;
    logic tick;
    logic [1:0] rot2;
    logic [1:0] rot3;
    logic [2:0] inv;
    logic [2:0] cmd;
    logic [2:0] cmd_cap;
    logic base;
    logic glitch;
    logic step_fail;
    logic fault;
    logic alarm;
    logic ai_fault;
    logic sw_fail;
    logic stuck_on;
    logic stuck_off;
    logic [2:0] out_disc;
    logic [2:0] cal_bad;
    logic [2:0][W-1:0] offset;
    logic [2:0][W-1:0] span;
  } tmrd_st_type;

  tmrd_st_type st_ff;
  tmrd_st_type nxt_st;
  tmrd_vote_if vif ();
  logic mc_stb;
  logic [2:0] mc_odd;
  logic mc_fault;
  logic [8:0] mc_run;
  logic abort;
  logic voted;

  function automatic logic [1:0] next3(input logic [1:0] r);
    next3 = (r == 2'h2) ? 2'h0 : r + 2'h1;
  endfunction

  function automatic logic [W-1:0] adiff(input logic [W-1:0] x,
                                         input logic [W-1:0] y);
    adiff = (x > y) ? x - y : y - x;
  endfunction

  // ==========================================================
  // Submodules
  assign mc_stb = direct_mode ? st_ff.tick : iso_sample_stb;

  tmrd_mis_cmp #(
    .W(W)
  ) u_mis_cmp (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sample_stb(mc_stb),
    .direct_mode(direct_mode),
    .leg_val(leg_sample),
    .odd_leg(mc_odd),
    .persist_fault(mc_fault),
    .run_len(mc_run)
  );

  assign vif.cmd = st_ff.cmd;
  assign vif.inv = st_ff.inv;

  tmrd_voter u_voter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .vif(vif)
  );

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    voted = tmrd_pkg::tmrd_maj(st_ff.cmd);
    // Command changes mid test would make any verdict meaningless
    abort = st_ff.cmd != st_ff.cmd_cap;
    nxt_st.cmd = leg_cmd;
    nxt_st.step_fail = 1'b0;
    nxt_st.cal_bad = 3'h0;
    nxt_st.alarm = st_ff.fault;
    nxt_st.out_disc = {3{voted}} ^ st_ff.cmd;
    // Sample pacing for the direct coupled variant
    if (st_ff.smp >= SAMPLE_CYC - 1) begin
      nxt_st.smp = 32'h0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.smp = st_ff.smp + 32'h1;
      nxt_st.tick = 1'b0;
    end
    // Self calibration, references must both be in tolerance
    if (cal_stb && direct_mode) begin
      for (int i = 0; i < 3; i++) begin
        if (adiff(cal_lo_meas[i], REF_LO) <= CAL_TOL &&
            adiff(cal_hi_meas[i], REF_HI) <= CAL_TOL) begin
          nxt_st.offset[i] = cal_lo_meas[i] - REF_LO;
          nxt_st.span[i] = cal_hi_meas[i] - cal_lo_meas[i];
        end else begin
          nxt_st.cal_bad[i] = 1'b1;
        end
      end
    end
    // Sticky flags: clear first so a same cycle set wins
    if (fault_clear) begin
      nxt_st.fault = 1'b0;
      nxt_st.ai_fault = 1'b0;
      nxt_st.sw_fail = 1'b0;
      nxt_st.stuck_on = 1'b0;
      nxt_st.stuck_off = 1'b0;
    end
    if (mc_fault) begin
      nxt_st.ai_fault = 1'b1;
    end
    if (mc_fault || (|st_ff.cal_bad) || st_ff.step_fail) begin
      nxt_st.fault = 1'b1;
    end
    if (|mp_fault_cmd) begin
      nxt_st.fault = 1'b1;
    end
    // Output self check sequence
    case (st_ff.ov)
      tmrd_pkg::OV_IDLE: begin
        nxt_st.inv = tmrd_pkg::INV_RST;
        if (st_ff.tmr >= DIAG_GAP_CYC - 1) begin
          nxt_st.tmr = 32'h0;
          nxt_st.ov = tmrd_pkg::OV_STEP1;
        end else begin
          nxt_st.tmr = st_ff.tmr + 32'h1;
        end
      end
      tmrd_pkg::OV_STEP1: begin
        nxt_st.cmd_cap = st_ff.cmd;
        nxt_st.base = load_sense;
        nxt_st.glitch = 1'b0;
        nxt_st.tmr = 32'h0;
        if (load_sense != voted) begin
          nxt_st.step_fail = 1'b1;
          nxt_st.ov = tmrd_pkg::OV_IDLE;
        end else begin
          nxt_st.inv = 3'h1 << st_ff.rot2;
          nxt_st.ov = tmrd_pkg::OV_STEP2;
        end
      end
      tmrd_pkg::OV_STEP2: begin
        if (load_sense != st_ff.base) begin
          nxt_st.glitch = 1'b1;
        end
        if (abort) begin
          nxt_st.inv = tmrd_pkg::INV_RST;
          nxt_st.tmr = 32'h0;
          nxt_st.ov = tmrd_pkg::OV_IDLE;
        end else if (st_ff.tmr >= STEP2_CYC - 1) begin
          nxt_st.inv = tmrd_pkg::INV_RST;
          nxt_st.tmr = 32'h0;
          nxt_st.rot2 = next3(st_ff.rot2);
          if (st_ff.glitch || load_sense != st_ff.base) begin
            nxt_st.step_fail = 1'b1;
            nxt_st.sw_fail = 1'b1;
            nxt_st.ov = tmrd_pkg::OV_IDLE;
          end else if (triac_mode) begin
            nxt_st.ov = tmrd_pkg::OV_IDLE;
          end else begin
            nxt_st.glitch = 1'b0;
            case (st_ff.rot3)
              2'h0: nxt_st.inv = 3'h3;
              2'h1: nxt_st.inv = 3'h6;
              default: nxt_st.inv = 3'h5;
            endcase
            nxt_st.ov = tmrd_pkg::OV_STEP3;
          end
        end else begin
          nxt_st.tmr = st_ff.tmr + 32'h1;
        end
      end
      tmrd_pkg::OV_STEP3: begin
        if (load_sense != st_ff.base) begin
          nxt_st.glitch = 1'b1;
        end
        if (abort) begin
          nxt_st.inv = tmrd_pkg::INV_RST;
          nxt_st.tmr = 32'h0;
          nxt_st.ov = tmrd_pkg::OV_IDLE;
        end else if (st_ff.tmr >= INV3_CYC - 1) begin
          nxt_st.inv = tmrd_pkg::INV_RST;
          nxt_st.tmr = 32'h0;
          nxt_st.ov = tmrd_pkg::OV_WATCH;
        end else begin
          nxt_st.tmr = st_ff.tmr + 32'h1;
        end
      end
      tmrd_pkg::OV_WATCH: begin
        nxt_st.inv = tmrd_pkg::INV_RST;
        if (load_sense != st_ff.base) begin
          nxt_st.glitch = 1'b1;
        end
        if (abort) begin
          nxt_st.tmr = 32'h0;
          nxt_st.ov = tmrd_pkg::OV_IDLE;
        end else if (st_ff.tmr >= WATCH_CYC - 1) begin
          nxt_st.tmr = 32'h0;
          nxt_st.rot3 = next3(st_ff.rot3);
          nxt_st.ov = tmrd_pkg::OV_IDLE;
          if (!st_ff.glitch) begin
            nxt_st.step_fail = 1'b1;
            if (st_ff.base) begin
              nxt_st.stuck_on = 1'b1;
            end else begin
              nxt_st.stuck_off = 1'b1;
            end
          end
        end else begin
          nxt_st.tmr = st_ff.tmr + 32'h1;
        end
      end
      default: begin
        nxt_st.inv = tmrd_pkg::INV_RST;
        nxt_st.tmr = 32'h0;
        nxt_st.ov = tmrd_pkg::OV_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign load_drive = vif.drive;
  assign fault_led = st_ff.fault;
  assign chassis_alarm = st_ff.alarm;
  assign ai_leg_report = mc_odd;
  assign ai_input_fault = st_ff.ai_fault;
  assign cal_leg_bad = st_ff.cal_bad;
  assign cal_offset = st_ff.offset;
  assign cal_span = st_ff.span;
  assign out_disc = st_ff.out_disc;
  assign sw_fail = st_ff.sw_fail;
  assign stuck_on = st_ff.stuck_on;
  assign stuck_off = st_ff.stuck_off;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_alarm;
    fault_led |=> chassis_alarm;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm did not follow fault");

  property p_mp_fault;
    |mp_fault_cmd |=> fault_led;
  endproperty
  a_mp_fault: assert property (p_mp_fault)
    else $error("processor fault command ignored");

  property p_cal;
    cal_stb && direct_mode &&
      adiff(cal_lo_meas[0], REF_LO) > CAL_TOL |=> cal_leg_bad[0] ##1 fault_led;
  endproperty
  a_cal: assert property (p_cal)
    else $error("out of tolerance reference not flagged");

  property p_vote;
    ##1 load_drive == tmrd_pkg::tmrd_maj($past(vif.cmd ^ vif.inv));
  endproperty
  a_vote: assert property (p_vote)
    else $error("load drive is not the majority");

  property p_mask;
    $countones(vif.inv) <= 1 && (&vif.cmd || ~|vif.cmd) |=>
      load_drive == $past(vif.cmd[0]);
  endproperty
  a_mask: assert property (p_mask)
    else $error("single leg upset reached the load");

  property p_step1;
    st_ff.ov == tmrd_pkg::OV_STEP1 && load_sense != voted |=>
      st_ff.ov == tmrd_pkg::OV_IDLE ##1 fault_led;
  endproperty
  a_step1: assert property (p_step1)
    else $error("step one mismatch did not stop the test");

  property p_step2;
    st_ff.ov == tmrd_pkg::OV_STEP2 |-> $onehot(st_ff.inv);
  endproperty
  a_step2: assert property (p_step2)
    else $error("step two does not invert one leg");

  property p_rot2;
    st_ff.ov == tmrd_pkg::OV_STEP2 && nxt_st.ov != tmrd_pkg::OV_STEP2 &&
      !abort |=> st_ff.rot2 == next3($past(st_ff.rot2));
  endproperty
  a_rot2: assert property (p_rot2)
    else $error("single leg rotation did not advance");

  property p_step3;
    st_ff.ov == tmrd_pkg::OV_STEP3 |-> $countones(st_ff.inv) == 2 &&
      st_ff.tmr < GLITCH_CYC;
  endproperty
  a_step3: assert property (p_step3)
    else $error("step three inversion wrong or too long");

  property p_rot3;
    st_ff.ov == tmrd_pkg::OV_WATCH && nxt_st.ov == tmrd_pkg::OV_IDLE &&
      !abort |=> st_ff.rot3 == next3($past(st_ff.rot3));
  endproperty
  a_rot3: assert property (p_rot3)
    else $error("pair rotation did not advance");

  property p_triac;
    triac_mode && st_ff.ov == tmrd_pkg::OV_STEP2 |=>
      st_ff.ov != tmrd_pkg::OV_STEP3;
  endproperty
  a_triac: assert property (p_triac)
    else $error("triac variant entered step three");

  property p_disc;
    ##1 out_disc == ({3{tmrd_pkg::tmrd_maj($past(st_ff.cmd))}} ^
      $past(st_ff.cmd));
  endproperty
  a_disc: assert property (p_disc)
    else $error("leg table discrepancy misreported");

  c_step3: cover property (st_ff.ov == tmrd_pkg::OV_WATCH ##1
    st_ff.ov == tmrd_pkg::OV_IDLE);
  c_step2_fail: cover property (st_ff.ov == tmrd_pkg::OV_STEP2 ##1 sw_fail);
  c_ai_fault: cover property (mc_fault);
  c_triac_skip: cover property (triac_mode &&
    st_ff.ov == tmrd_pkg::OV_STEP2 ##1 st_ff.ov == tmrd_pkg::OV_IDLE);
endmodule
`default_nettype wire

// ===== design/tmrd_mis_cmp.sv
`timescale 1ns/10ps
`default_nettype none
module tmrd_mis_cmp #(
  parameter int W = 12
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sample_stb,
  input wire logic direct_mode,
  input wire logic [2:0][W-1:0] leg_val,
  output logic [2:0] odd_leg,
  output logic persist_fault,
  output logic [8:0] run_len
);
  // ==========================================================
  // Thresholds, rounded up so a smaller change never counts
  localparam int unsigned FS = (2 ** W) - 1;
  localparam int unsigned THR_ISO =
    (FS * tmrd_pkg::ISO_DEV_BP + tmrd_pkg::BP_SCALE - 1) / tmrd_pkg::BP_SCALE;
  localparam int unsigned THR_DC =
    (FS * tmrd_pkg::DC_DEV_BP + tmrd_pkg::BP_SCALE - 1) / tmrd_pkg::BP_SCALE;

  typedef struct packed {
    logic [8:0] cnt;
    logic [2:0] odd;
    logic flt;
  } tmrd_mc_type;

  tmrd_mc_type st_ff;
  tmrd_mc_type nxt_st;
  logic [W-1:0] thr;
  logic [8:0] lim;
  logic far_ab;
  logic far_bc;
  logic far_ac;
  logic dev;

  function automatic logic [W-1:0] adiff(input logic [W-1:0] x,
                                         input logic [W-1:0] y);
    adiff = (x > y) ? x - y : y - x;
  endfunction

  // ==========================================================
  // Deviation detect and persistence count
  always_comb begin
    thr = direct_mode ? W'(THR_DC) : W'(THR_ISO);
    lim = direct_mode ? 9'(tmrd_pkg::DC_PERSIST) : 9'(tmrd_pkg::ISO_PERSIST);
    far_ab = adiff(leg_val[0], leg_val[1]) >= thr;
    far_bc = adiff(leg_val[1], leg_val[2]) >= thr;
    far_ac = adiff(leg_val[0], leg_val[2]) >= thr;
    dev = far_ab | far_bc | far_ac;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.odd = 3'h0;
    nxt_st.flt = 1'b0;
    if (sample_stb) begin
      if (dev) begin
        // A leg far from both neighbours is the one reported
        nxt_st.odd = {far_bc & far_ac, far_ab & far_bc, far_ab & far_ac};
        if (st_ff.cnt < lim) begin
          nxt_st.cnt = st_ff.cnt + 9'h1;
        end
        if (st_ff.cnt == lim - 9'h1) begin
          nxt_st.flt = 1'b1;
        end
      end else begin
        nxt_st.cnt = 9'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign odd_leg = st_ff.odd;
  assign persist_fault = st_ff.flt;
  assign run_len = st_ff.cnt;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_persist;
    persist_fault |-> run_len == lim;
  endproperty
  a_persist: assert property (p_persist)
    else $error("persist fault without full run");

  property p_restart;
    sample_stb && !dev |=> run_len == 9'h0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("agreeing sample did not restart count");

  property p_count;
    sample_stb && dev && run_len < lim |=> run_len == $past(run_len) + 9'h1;
  endproperty
  a_count: assert property (p_count)
    else $error("deviating sample not counted");
endmodule
`default_nettype wire

// ===== design/tmrd_pkg.sv
package tmrd_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SAMPLE_MS = 20;
  localparam int unsigned SAMPLE_CYC = SAMPLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned GLITCH_US = 2000;
  localparam int unsigned GLITCH_CYC = GLITCH_US * CLK_MHZ;
  // Inversion is kept well below the glitch limit to leave margin
  localparam int unsigned INV3_CYC = GLITCH_CYC / 4;
  localparam int unsigned WATCH_CYC = GLITCH_CYC;
  localparam int unsigned STEP2_CYC = 1000;
  localparam int unsigned DIAG_GAP_CYC = 100000;
  // ==========================================================
  // Deviation thresholds and persistence
  localparam int unsigned ISO_DEV_BP = 50;
  localparam int unsigned DC_DEV_BP = 25;
  localparam int unsigned BP_SCALE = 10000;
  localparam int unsigned ISO_PERSIST = 256;
  localparam int unsigned DC_PERSIST = 25;
  // ==========================================================
  // Reset values
  localparam logic [1:0] ROT_RST = 2'h0;
  localparam logic [2:0] INV_RST = 3'h0;
  // ==========================================================
  // Output self check sequencer
  typedef enum logic [2:0] {
    OV_IDLE = 3'h0,
    OV_STEP1 = 3'h1,
    OV_STEP2 = 3'h2,
    OV_STEP3 = 3'h3,
    OV_WATCH = 3'h4
  } tmrd_ov_state_type;

  function automatic logic tmrd_maj(input logic [2:0] v);
    tmrd_maj = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction
endpackage

// ===== design/tmrd_vote_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tmrd_vote_if;
  logic [2:0] cmd;
  logic [2:0] inv;
  logic drive;
  modport ctrl (output cmd, output inv, input drive);
  modport voter (input cmd, input inv, output drive);
endinterface
`default_nettype wire

// ===== design/tmrd_voter.sv
`timescale 1ns/10ps
`default_nettype none
module tmrd_voter (
  input wire logic core_clk,
  input wire logic arst_n,
  tmrd_vote_if.voter vif
);
  // ==========================================================
  // State
  typedef struct packed {
    logic drive;
  } tmrd_vt_type;

  tmrd_vt_type st_ff;
  tmrd_vt_type nxt_st;

  // ==========================================================
  // Two out of three vote on the possibly inverted leg commands
  always_comb begin
    nxt_st = st_ff;
    nxt_st.drive = tmrd_pkg::tmrd_maj(vif.cmd ^ vif.inv);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign vif.drive = st_ff.drive;
endmodule
`default_nettype wire
